//--- rtl/touch_report_and_fault_regs.sv
// Purpose: touch status, event queue, fault and low power registers
// Assumes: scl and sda oversampled by clk; sensing inputs on clk
// Notes:   sda is open drain; sda_out is always low when enabled
`timescale 1ns/1ps
module touch_report_and_fault_regs (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [7:0] touch_state,
  input  wire logic       event_valid,
  input  wire logic       event_press,
  input  wire logic [2:0] event_index,
  input  wire logic [7:0] short_to_ground,
  input  wire logic [7:0] short_to_supply,
  input  wire logic [3:0] max_key_count_setting,
  input  wire logic       run_mode,
  input  wire logic       duty_cycled_run_mode,
  input  wire logic       sample_tick,
  input  wire logic       touch_detected,
  output logic            scan_enable,
  output logic            scan_strobe,
  output logic            slow_scan_period,
  output logic            data_irq,
  output logic            fault_irq
);
  function automatic logic [7:0] lowest_one(input logic [7:0] v);
    return v & 8'(~v + 8'h01);
  endfunction : lowest_one

  function automatic logic [4:0] ptr_inc(input logic [4:0] p);
    return (p == touch_report_pkg::PTR_LAST) ? 5'h00 : 5'(p + 5'h01);
  endfunction : ptr_inc

  function automatic logic [3:0] count_ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < touch_report_pkg::ELECTRODES; i++) begin
      n = 4'(n + {3'h0, v[i]});
    end
    return n;
  endfunction : count_ones

  logic [1:0] rst_sync;
  logic       rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // pin synchronisers and edge detection on the second stage
  logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {scl_meta, scl_s, scl_d} <= 3'h7;
      {sda_meta, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_meta, scl_s, scl_d} <= {scl, scl_meta, scl_s};
      {sda_meta, sda_s, sda_d} <= {sda_in, sda_meta, sda_s};
    end
  end
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

  // register state
  logic [7:0] sleep_timing_config, electrode_touch_state;
  logic [1:0] fault;
  logic       too_many_keys_flag;
  logic [3:0] mem [touch_report_pkg::DEPTH];
  logic [4:0] wr_ptr, rd_ptr, count;
  logic       queue_overflow_flag;
  logic       buffer_empty_flag, more_entries_flag;
  assign buffer_empty_flag = (count == 5'h00);
  assign more_entries_flag = (count > 5'h01);
  assign scan_enable = run_mode & (fault == touch_report_pkg::FAULT_NONE);

  // link state machine
  touch_report_pkg::link_state_e state, next_state;
  logic [7:0] sh, next_sh, ptr, next_ptr, tx_byte;
  logic [3:0] bitcnt, next_bitcnt;
  logic       rw, next_rw, next_sda_oe, wr_strobe, rd_load;

  always_comb begin
    tx_byte = 8'h00;
    unique case (ptr)
      touch_report_pkg::ADDR_QUEUE: begin
        tx_byte[touch_report_pkg::MORE_BIT]  = more_entries_flag;
        tx_byte[touch_report_pkg::EMPTY_BIT] = buffer_empty_flag;
        tx_byte[touch_report_pkg::OVF_BIT]   = queue_overflow_flag;
        if (!buffer_empty_flag) begin
          tx_byte[touch_report_pkg::PRESS_BIT:0] = {mem[rd_ptr][3], 1'b0,
                                                    mem[rd_ptr][2:0]};
        end
      end
      touch_report_pkg::ADDR_FAULT: begin
        tx_byte[touch_report_pkg::MANY_BIT] = too_many_keys_flag;
        tx_byte[1:0] = fault;
      end
      touch_report_pkg::ADDR_TOUCH: tx_byte = electrode_touch_state;
      touch_report_pkg::ADDR_SLEEP: tx_byte = sleep_timing_config;
      default: tx_byte = 8'h00;
    endcase
  end

  always_comb begin
    next_state  = state;
    next_sh     = sh;
    next_ptr    = ptr;
    next_bitcnt = bitcnt;
    next_rw     = rw;
    next_sda_oe = sda_oe;
    wr_strobe   = 1'b0;
    rd_load     = 1'b0;
    if (start_cond) begin
      next_state  = touch_report_pkg::st_addr;
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_state  = touch_report_pkg::st_idle;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        touch_report_pkg::st_idle: next_sda_oe = 1'b0;
        touch_report_pkg::st_addr, touch_report_pkg::st_ptr,
        touch_report_pkg::st_wdata: begin
          if (scl_rise) begin
            next_sh     = {sh[6:0], sda_s};
            next_bitcnt = 4'(bitcnt + 4'h1);
          end else if (scl_fall && bitcnt == touch_report_pkg::BYTE_DONE) begin
            next_bitcnt = 4'h0;
            next_sda_oe = 1'b1;
            if (state == touch_report_pkg::st_addr) begin
              next_rw    = sh[0];
              next_state = (sh[7:1] == touch_report_pkg::DEV_ADDR)
                           ? touch_report_pkg::st_addr_ack
                           : touch_report_pkg::st_idle;
              next_sda_oe = (sh[7:1] == touch_report_pkg::DEV_ADDR);
            end else if (state == touch_report_pkg::st_ptr) begin
              next_ptr   = sh;
              next_state = touch_report_pkg::st_ptr_ack;
            end else begin
              wr_strobe  = 1'b1;
              next_state = touch_report_pkg::st_wdata_ack;
            end
          end
        end
        touch_report_pkg::st_addr_ack,
        touch_report_pkg::st_rdata_next: begin
          if (scl_fall) begin
            if (rw) begin
              rd_load     = 1'b1;
              next_sh     = tx_byte;
              next_sda_oe = ~tx_byte[7];
              next_bitcnt = 4'h1;
              next_state  = touch_report_pkg::st_rdata;
            end else begin
              next_sda_oe = 1'b0;
              next_state  = touch_report_pkg::st_ptr;
            end
          end
        end
        touch_report_pkg::st_ptr_ack, touch_report_pkg::st_wdata_ack: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_state  = touch_report_pkg::st_wdata;
          end
        end
        touch_report_pkg::st_rdata: begin
          if (scl_fall) begin
            if (bitcnt == touch_report_pkg::BYTE_DONE) begin
              next_sda_oe = 1'b0;
              next_state  = touch_report_pkg::st_rdata_ack;
            end else begin
              next_sh     = {sh[6:0], 1'b0};
              next_sda_oe = ~sh[6];
              next_bitcnt = 4'(bitcnt + 4'h1);
            end
          end
        end
        touch_report_pkg::st_rdata_ack: begin
          if (scl_rise) begin
            next_state = sda_s ? touch_report_pkg::st_idle
                               : touch_report_pkg::st_rdata_next;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= touch_report_pkg::st_idle;
      sh     <= 8'h00;
      ptr    <= 8'h00;
      bitcnt <= 4'h0;
      rw     <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      state  <= next_state;
      sh     <= next_sh;
      ptr    <= next_ptr;
      bitcnt <= next_bitcnt;
      rw     <= next_rw;
      sda_oe <= next_sda_oe;
    end
  end
  assign sda_out = 1'b0;

  logic queue_access, queue_clear, pop, wr_fault;
  assign queue_access = (rd_load | wr_strobe) &
                        (ptr == touch_report_pkg::ADDR_QUEUE);
  assign queue_clear = wr_strobe & (ptr == touch_report_pkg::ADDR_QUEUE);
  assign pop = rd_load & (ptr == touch_report_pkg::ADDR_QUEUE) &
               ~buffer_empty_flag;
  assign wr_fault = wr_strobe & (ptr == touch_report_pkg::ADDR_FAULT);

  // event queue, status and configuration registers
  logic [3:0] next_mem [touch_report_pkg::DEPTH];
  logic [4:0] next_wr, next_rd, next_count;
  logic [7:0] next_cfg, next_touch, shorts, first_short;
  logic [1:0] next_fault;
  logic       next_ovf, next_many;

  always_comb begin
    next_mem   = mem;
    next_wr    = queue_clear ? 5'h00 : wr_ptr;
    next_rd    = queue_clear ? 5'h00 : (pop ? ptr_inc(rd_ptr) : rd_ptr);
    next_count = queue_clear ? 5'h00 : 5'(count - {4'h0, pop});
    next_ovf   = queue_clear ? 1'b0 : queue_overflow_flag;
    if (!queue_clear && pop && count == 5'h01) next_ovf = 1'b0;
    if (event_valid) begin
      if (next_count == touch_report_pkg::DEPTH_C) begin
        next_ovf = 1'b1;
      end else begin
        next_mem[next_wr] = {event_press, event_index};
        next_wr    = ptr_inc(next_wr);
        next_count = 5'(next_count + 5'h01);
      end
    end
    next_cfg = sleep_timing_config;
    if (wr_strobe && ptr == touch_report_pkg::ADDR_SLEEP) next_cfg = sh;
    next_touch  = lowest_one(touch_state);
    next_many   = count_ones(touch_state) > max_key_count_setting;
    shorts      = short_to_ground | short_to_supply;
    first_short = lowest_one(shorts);
    next_fault  = fault;
    if (wr_fault && !run_mode) begin
      next_fault = touch_report_pkg::FAULT_NONE;
    end else if (scan_enable && shorts != 8'h00) begin
      next_fault = ((first_short & short_to_ground) != 8'h00)
                   ? touch_report_pkg::FAULT_GND
                   : touch_report_pkg::FAULT_SUP;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < touch_report_pkg::DEPTH; i++) mem[i] <= 4'h0;
      wr_ptr                <= 5'h00;
      rd_ptr                <= 5'h00;
      count                 <= 5'h00;
      queue_overflow_flag   <= 1'b0;
      sleep_timing_config   <= touch_report_pkg::SLEEP_RESET;
      electrode_touch_state <= 8'h00;
      too_many_keys_flag    <= 1'b0;
      fault                 <= touch_report_pkg::FAULT_NONE;
    end else begin
      mem                   <= next_mem;
      wr_ptr                <= next_wr;
      rd_ptr                <= next_rd;
      count                 <= next_count;
      queue_overflow_flag   <= next_ovf;
      sleep_timing_config   <= next_cfg;
      electrode_touch_state <= next_touch;
      too_many_keys_flag    <= next_many;
      fault                 <= next_fault;
    end
  end

  // interrupt sources
  logic empty_prev, armed, next_data_irq, next_armed, next_fault_irq;
  always_comb begin
    next_data_irq  = data_irq;
    next_armed     = armed;
    next_fault_irq = fault_irq;
    if (queue_access) next_data_irq = 1'b0;
    if (empty_prev && !buffer_empty_flag && armed) begin
      next_data_irq = 1'b1;
      next_armed    = 1'b0;
    end
    if (buffer_empty_flag) next_armed = 1'b1;
    if (wr_fault) next_fault_irq = 1'b0;
    if (fault == touch_report_pkg::FAULT_NONE &&
        next_fault != touch_report_pkg::FAULT_NONE) begin
      next_fault_irq = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      empty_prev <= 1'b1;
      armed      <= 1'b1;
      data_irq   <= 1'b0;
      fault_irq  <= 1'b0;
    end else begin
      empty_prev <= buffer_empty_flag;
      armed      <= next_armed;
      data_irq   <= next_data_irq;
      fault_irq  <= next_fault_irq;
    end
  end

  // duty cycled scan period selection
  logic [2:0] idle_timeout_factor, idle_cnt, next_idle_cnt;
  logic [4:0] sleep_duration_factor, sleep_cnt, next_sleep_cnt;
  logic       lp_on, next_slow, next_strobe;
  assign idle_timeout_factor = sleep_timing_config[touch_report_pkg::IDLE_MSB:
                                                   touch_report_pkg::IDLE_LSB];
  assign sleep_duration_factor = sleep_timing_config[
    touch_report_pkg::SLEEP_MSB:touch_report_pkg::SLEEP_LSB];
  assign lp_on = (idle_timeout_factor != 3'h0) &&
                 (sleep_duration_factor != 5'h00) &&
                 duty_cycled_run_mode && scan_enable;

  always_comb begin
    next_slow      = slow_scan_period;
    next_idle_cnt  = idle_cnt;
    next_sleep_cnt = sleep_cnt;
    next_strobe    = 1'b0;
    if (!lp_on || touch_detected) begin
      next_slow      = 1'b0;
      next_idle_cnt  = 3'h0;
      next_sleep_cnt = 5'h00;
      next_strobe    = sample_tick & scan_enable;
    end else if (sample_tick) begin
      if (!slow_scan_period) begin
        next_strobe = 1'b1;
        if (3'(idle_cnt + 3'h1) == idle_timeout_factor) begin
          next_slow     = 1'b1;
          next_idle_cnt = 3'h0;
        end else begin
          next_idle_cnt = 3'(idle_cnt + 3'h1);
        end
      end else if (5'(sleep_cnt + 5'h01) == sleep_duration_factor) begin
        next_strobe    = 1'b1;
        next_sleep_cnt = 5'h00;
      end else begin
        next_sleep_cnt = 5'(sleep_cnt + 5'h01);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_scan_period <= 1'b0;
      idle_cnt         <= 3'h0;
      sleep_cnt        <= 5'h00;
      scan_strobe      <= 1'b0;
    end else begin
      slow_scan_period <= next_slow;
      idle_cnt         <= next_idle_cnt;
      sleep_cnt        <= next_sleep_cnt;
      scan_strobe      <= next_strobe;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_QUEUE_CLEAR: assert property (queue_clear && !event_valid |=>
    buffer_empty_flag && !queue_overflow_flag) else $error("clear failed");
  AST_QUEUE_BOUND: assert property (count <= touch_report_pkg::DEPTH_C)
    else $error("queue count above depth");
  AST_OVERFLOW: assert property (event_valid && !pop && !queue_clear &&
    count == touch_report_pkg::DEPTH_C |=> queue_overflow_flag &&
    count == touch_report_pkg::DEPTH_C && wr_ptr == $past(wr_ptr))
    else $error("overflow changed queue");
  AST_POP: assert property (pop && !event_valid && !queue_clear |=>
    count == 5'($past(count) - 5'h01) && rd_ptr != $past(rd_ptr))
    else $error("read did not remove entry");
  AST_FAULT_HOLD: assert property (wr_fault && run_mode &&
    fault != touch_report_pkg::FAULT_NONE |=> fault == $past(fault))
    else $error("fault cleared in run mode");
  AST_SCAN_STOP: assert property (fault != touch_report_pkg::FAULT_NONE
    |-> !scan_enable ##1 !scan_strobe)
    else $error("scanning during fault");
  AST_ONE_POSITION: assert property ($onehot0(electrode_touch_state))
    else $error("more than one position shown");
  AST_LP_OFF: assert property (idle_timeout_factor == 3'h0 |=>
    !slow_scan_period) else $error("low power while disabled");
  AST_FAULT_IRQ: assert property (fault == touch_report_pkg::FAULT_NONE
    ##1 fault != touch_report_pkg::FAULT_NONE |-> fault_irq)
    else $error("fault interrupt missing");
  AST_DATA_IRQ: assert property ($fell(buffer_empty_flag) &&
    $past(armed) |=> data_irq) else $error("data interrupt missing");
  COV_OVERFLOW: cover property (event_valid &&
    count == touch_report_pkg::DEPTH_C);
  COV_READ_LAST: cover property (pop && count == 5'h01);
  COV_SLOW: cover property ($rose(slow_scan_period));
  COV_FAULT_CLEAR: cover property (wr_fault && !run_mode &&
    fault != touch_report_pkg::FAULT_NONE);
endmodule : touch_report_and_fault_regs

//--- rtl/touch_report_pkg.sv
// Purpose: constants and types of the touch report and fault registers
// Assumes: 8 electrodes, byte wide registers on a two-wire serial link
// Notes:   device bus address below is arbitrary
package touch_report_pkg;
  localparam logic [6:0] DEV_ADDR    = 7'h5d; // arbitrary value
  localparam logic [7:0] ADDR_QUEUE  = 8'h00;
  localparam logic [7:0] ADDR_FAULT  = 8'h01;
  localparam logic [7:0] ADDR_TOUCH  = 8'h02;
  localparam logic [7:0] ADDR_SLEEP  = 8'h11;
  localparam logic [7:0] SLEEP_RESET = 8'h00;
  localparam int         IDLE_MSB    = 7;
  localparam int         IDLE_LSB    = 5;
  localparam int         SLEEP_MSB   = 4;
  localparam int         SLEEP_LSB   = 0;
  localparam int         MORE_BIT    = 7;
  localparam int         EMPTY_BIT   = 6;
  localparam int         OVF_BIT     = 5;
  localparam int         PRESS_BIT   = 4;
  localparam int         MANY_BIT    = 4;
  localparam int         ELECTRODES  = 8;
  localparam int         DEPTH       = 30;
  localparam logic [4:0] DEPTH_C     = 5'h1e;
  localparam logic [4:0] PTR_LAST    = 5'h1d;
  localparam logic [3:0] BYTE_DONE   = 4'h8;
  localparam logic [1:0] FAULT_NONE  = 2'h0;
  localparam logic [1:0] FAULT_GND   = 2'h1;
  localparam logic [1:0] FAULT_SUP   = 2'h2;
  typedef enum {
    st_idle, st_addr, st_addr_ack, st_ptr, st_ptr_ack,
    st_wdata, st_wdata_ack, st_rdata, st_rdata_ack, st_rdata_next
  } link_state_e;
endpackage : touch_report_pkg

//--- tb/touch_link_host.sv
// Purpose: host model driving the two-wire register link
// Assumes: device pulls sda low to drive; line pulled up when released
// Notes:   scl stands high outside frames; 800 ns link period
`timescale 1ns/1ps
module touch_link_host (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  task automatic start_cond();
    sda_drv = 1'b1;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_drv = 1'b0;
    wait_clk(4);
    scl = 1'b0;
    wait_clk(2);
  endtask : start_cond

  task automatic stop_cond();
    sda_drv = 1'b0;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_drv = 1'b1;
    wait_clk(4);
  endtask : stop_cond

  // one bit: data set mid low phase, sampled at end of high phase
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    r = sda_line;
    scl = 1'b0;
    wait_clk(2);
  endtask : bit_io

  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask : xfer

  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] data,
                           output logic [2:0] acks);
    logic [7:0] rx;
    start_cond();
    xfer({touch_report_pkg::DEV_ADDR, 1'b0}, 1'b1, rx, acks[2]);
    xfer(ptr, 1'b1, rx, acks[1]);
    xfer(data, 1'b1, rx, acks[0]);
    stop_cond();
  endtask : reg_write

  // read one byte then refuse more
  task automatic reg_read(input logic [7:0] ptr, output logic [7:0] data,
                          output logic [2:0] acks);
    logic [7:0] rx;
    logic       nack;
    start_cond();
    xfer({touch_report_pkg::DEV_ADDR, 1'b0}, 1'b1, rx, acks[2]);
    xfer(ptr, 1'b1, rx, acks[1]);
    start_cond();
    xfer({touch_report_pkg::DEV_ADDR, 1'b1}, 1'b1, rx, acks[0]);
    xfer(8'hff, 1'b1, data, nack);
    stop_cond();
  endtask : reg_read
endmodule : touch_link_host

//--- tb/touch_report_and_fault_regs_test.sv
// Purpose: self-checking bench of the touch report and fault registers
// Assumes: host model speaks the register link; inputs change at negedge
// Notes:   expectations derived from register layout and package constants
`timescale 1ns/1ps
module touch_report_and_fault_regs_test;
  logic       clk, nrst, scl, sda_drv, sda_line, sda_out, sda_oe;
  logic [7:0] touch_state, short_to_ground, short_to_supply, rd;
  logic       event_valid, event_press, run_mode, duty_cycled_run_mode;
  logic [2:0] event_index, acks;
  logic [3:0] max_key_count_setting;
  logic       sample_tick, touch_detected, scan_enable, scan_strobe;
  logic       slow_scan_period, data_irq, fault_irq;
  int         num_errors, compares, strobes;
  logic [7:0] lp_cfg [2] = '{8'h20, 8'h02};

  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

  touch_link_host u_host (.clk(clk), .sda_line(sda_line), .scl(scl),
                          .sda_drv(sda_drv));

  touch_report_and_fault_regs u_dut (
    .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .touch_state(touch_state),
    .event_valid(event_valid), .event_press(event_press),
    .event_index(event_index), .short_to_ground(short_to_ground),
    .short_to_supply(short_to_supply),
    .max_key_count_setting(max_key_count_setting), .run_mode(run_mode),
    .duty_cycled_run_mode(duty_cycled_run_mode), .sample_tick(sample_tick),
    .touch_detected(touch_detected), .scan_enable(scan_enable),
    .scan_strobe(scan_strobe), .slow_scan_period(slow_scan_period),
    .data_irq(data_irq), .fault_irq(fault_irq));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  always @(posedge clk) begin
    if (scan_strobe === 1'b1) strobes = strobes + 1;
  end

  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic check8(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check8

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    u_host.reg_write(ptr, data, acks);
    check8("write ack", 8'h00, {5'h0, acks});
  endtask : wr

  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp,
                        input string name);
    u_host.reg_read(ptr, rd, acks);
    check8("read ack", 8'h00, {5'h0, acks});
    check8(name, exp, rd);
  endtask : rd_chk

  task automatic push(input logic press, input logic [2:0] idx);
    @(negedge clk);
    event_valid = 1'b1;
    event_press = press;
    event_index = idx;
    @(negedge clk);
    event_valid = 1'b0;
  endtask : push

  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk) sample_tick = 1'b1;
      @(negedge clk) sample_tick = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask : tick

  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  initial begin
    nrst = 1'b0;
    {touch_state, short_to_ground, short_to_supply} = '0;
    {event_valid, event_press, event_index, sample_tick} = '0;
    {run_mode, duty_cycled_run_mode, touch_detected} = '0;
    max_key_count_setting = 4'h8;
    strobes = 0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    rd_chk(touch_report_pkg::ADDR_SLEEP, 8'h00, "sleep");
    rd_chk(touch_report_pkg::ADDR_QUEUE, 8'h40, "queue");
    rd_chk(touch_report_pkg::ADDR_FAULT, 8'h00, "fault");
    wr(touch_report_pkg::ADDR_SLEEP, 8'ha5);
    rd_chk(touch_report_pkg::ADDR_SLEEP, 8'ha5, "sleep");
    for (int i = 0; i < 8; i++) begin
      touch_state = 8'h01 << i;
      rd_chk(touch_report_pkg::ADDR_TOUCH, 8'h01 << i, "touch");
    end
    touch_state = 8'hc4;
    wr(touch_report_pkg::ADDR_TOUCH, 8'hff);
    rd_chk(touch_report_pkg::ADDR_TOUCH, 8'h04, "touch one");
    // eight events, irq, one pop, a ninth event without new irq
    for (int i = 0; i < 8; i++) push(i[0], i[2:0]);
    repeat (3) @(negedge clk);
    check8("data irq", 8'h01, {7'h0, data_irq});
    rd_chk(touch_report_pkg::ADDR_QUEUE, 8'h80, "entry");
    push(1'b0, 3'h0);
    repeat (3) @(negedge clk);
    check8("data irq", 8'h00, {7'h0, data_irq});
    for (int i = 1; i < 9; i++)
      rd_chk(touch_report_pkg::ADDR_QUEUE,
             {i < 8, 2'b00, i[0], 1'b0, i[2:0]}, "entry");
    rd_chk(touch_report_pkg::ADDR_QUEUE, 8'h40, "emptied");
    // overflow: 31 events, 30 kept, flag clears with last read
    for (int i = 0; i < 31; i++) push(1'b1, 3'h5);
    for (int i = 0; i < 29; i++)
      rd_chk(touch_report_pkg::ADDR_QUEUE, 8'hb5, "overflow");
    rd_chk(touch_report_pkg::ADDR_QUEUE, 8'h35, "last");
    rd_chk(touch_report_pkg::ADDR_QUEUE, 8'h40, "ovf clear");
    push(1'b1, 3'h7);
    push(1'b0, 3'h2);
    wr(touch_report_pkg::ADDR_QUEUE, 8'h00);
    rd_chk(touch_report_pkg::ADDR_QUEUE, 8'h40, "cleared");
    // faults: ground first in scan order, then supply first
    for (int j = 0; j < 2; j++) begin
      run_mode = 1'b1;
      short_to_ground = j ? 8'h20 : 8'h10;
      short_to_supply = j ? 8'h08 : 8'h40;
      repeat (4) @(negedge clk);
      {short_to_ground, short_to_supply} = '0;
      repeat (2) @(negedge clk);
      check8("scan en", 8'h00, {7'h0, scan_enable});
      check8("fault irq", 8'h01, {7'h0, fault_irq});
      rd_chk(touch_report_pkg::ADDR_FAULT, 8'h01 << j, "code");
      wr(touch_report_pkg::ADDR_FAULT, 8'h00);
      rd_chk(touch_report_pkg::ADDR_FAULT, 8'h01 << j, "kept");
      run_mode = 1'b0;
      wr(touch_report_pkg::ADDR_FAULT, 8'h00);
      rd_chk(touch_report_pkg::ADDR_FAULT, 8'h00, "cleared");
      check8("fault irq", 8'h00, {7'h0, fault_irq});
    end
    max_key_count_setting = 4'h2;
    touch_state = 8'h07;
    rd_chk(touch_report_pkg::ADDR_FAULT, 8'h10, "many keys");
    touch_state = 8'h03;
    rd_chk(touch_report_pkg::ADDR_FAULT, 8'h00, "many keys");
    // low power: idle 1 sleep 2, then idle 7 sleep 1
    touch_state = 8'h00;
    run_mode = 1'b1;
    duty_cycled_run_mode = 1'b1;
    wr(touch_report_pkg::ADDR_SLEEP, 8'h22);
    tick(3);
    check8("slow", 8'h01, {7'h0, slow_scan_period});
    strobes = 0;
    tick(8);
    check8("slow strobes", 8'h04, strobes[7:0]);
    @(negedge clk) touch_detected = 1'b1;
    @(negedge clk) touch_detected = 1'b0;
    repeat (2) @(negedge clk);
    check8("fast", 8'h00, {7'h0, slow_scan_period});
    wr(touch_report_pkg::ADDR_SLEEP, 8'he1);
    @(negedge clk) touch_detected = 1'b1;
    @(negedge clk) touch_detected = 1'b0;
    tick(6);
    check8("idle 6", 8'h00, {7'h0, slow_scan_period});
    tick(1);
    check8("idle 7", 8'h01, {7'h0, slow_scan_period});
    for (int k = 0; k < 2; k++) begin
      wr(touch_report_pkg::ADDR_SLEEP, lp_cfg[k]);
      strobes = 0;
      tick(10);
      check8("disabled", 8'h00, {7'h0, slow_scan_period});
      check8("fast strobes", 8'h0a, strobes[7:0]);
    end
    stop_test();
  end
endmodule : touch_report_and_fault_regs_test
